// *** subtract_accumulator_with_borrow_pkg.sv ***
// Purpose: Constants and types for the subtract-with-borrow execution block.
// Assumes: APB slave with 32-bit data; 4 KiB of byte data memory.
// Notes: All offsets are byte addresses of aligned 32-bit words.
package subtract_accumulator_with_borrow_pkg;
  // Register byte offsets.
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] INSTR_OFS = 12'h004;
  localparam logic [11:0] ACC_OFS = 12'h008;
  localparam logic [11:0] BANK_OFS = 12'h00c;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam logic [11:0] INDEX_OFS = 12'h014;
  localparam logic [11:0] MADDR_OFS = 12'h018;
  localparam logic [11:0] MDATA_OFS = 12'h01c;
  localparam logic [11:0] RESULT_OFS = 12'h020;
  // Status flag positions and the control register's extended-mode bit.
  localparam int C_BIT = 0;
  localparam int NIBBLE_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int WRAP_BIT = 3;
  localparam int N_BIT = 4;
  localparam int BAD_BIT = 8;
  localparam int BUSY_BIT = 9;
  localparam int EXT_BIT = 0;
  // Instruction fields.
  localparam logic [5:0] OPCODE = 6'h16;
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  // Access bank split and indexed window limit.
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] LOW_BANK = 4'h0;
  localparam logic [3:0] HIGH_BANK = 4'hf;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam int MEM_WORDS = 4096;
  // Execution phases.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECODE = 3'b001,
    ST_READ = 3'b010,
    ST_PROCESS = 3'b011,
    ST_WRITE = 3'b100
  } state_t;
endpackage : subtract_accumulator_with_borrow_pkg

// *** subtract_with_borrow_exec.sv ***
// Purpose: Executes the subtract-accumulator-with-borrow instruction.
// Assumes: Software loads operands and the instruction word over APB.
// Notes: The bus stalls (pready low) while an instruction is in flight.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module subtract_with_borrow_exec (
  // Clock, reset and clock enable.
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Resolves the 12-bit operand address from f, a and the mode registers.
  function automatic logic [11:0] resolve(input logic [7:0] f,
      input logic a, input logic ext, input logic [3:0] bank,
      input logic [11:0] base);
    logic [11:0] r;
    r = {bank, f};
    if (!a && ext && (f <= subtract_accumulator_with_borrow_pkg::INDEX_LIMIT)) begin
      r = base + {4'h0, f};
    end else if (!a) begin
      r = {(f < subtract_accumulator_with_borrow_pkg::ACCESS_SPLIT) ? subtract_accumulator_with_borrow_pkg::LOW_BANK
           : subtract_accumulator_with_borrow_pkg::HIGH_BANK, f};
    end
    return r;
  endfunction : resolve

  // Width-limited subtract with borrow; the top bit is the borrow out.
  function automatic logic [8:0] sub_borrow(input logic [7:0] x,
      input logic [7:0] y, input logic bin);
    return {1'b0, x} - {1'b0, y} - {8'h00, bin};
  endfunction : sub_borrow

  subtract_accumulator_with_borrow_pkg::state_t state_q, state_d;
  logic [7:0] mem [subtract_accumulator_with_borrow_pkg::MEM_WORDS];
  logic ext_q;
  logic [15:0] instr_q;
  logic [7:0] w_q;
  logic [3:0] bank_q;
  logic [11:0] index_q;
  logic [11:0] maddr_q;
  logic [4:0] flags_q;
  logic bad_q;
  logic [11:0] ea_q;
  logic [7:0] oper_q;
  logic [7:0] res_q;
  logic [4:0] calc_q;
  logic [31:0] prdata_q;
  logic valid_q;

  // Bus decode.
  wire idle = (state_q == subtract_accumulator_with_borrow_pkg::ST_IDLE);
  wire busy = !idle;
  wire hit_ctrl = (paddr == subtract_accumulator_with_borrow_pkg::CTRL_OFS);
  wire hit_instr = (paddr == subtract_accumulator_with_borrow_pkg::INSTR_OFS);
  wire hit_acc = (paddr == subtract_accumulator_with_borrow_pkg::ACC_OFS);
  wire hit_bank = (paddr == subtract_accumulator_with_borrow_pkg::BANK_OFS);
  wire hit_stat = (paddr == subtract_accumulator_with_borrow_pkg::STATUS_OFS);
  wire hit_index = (paddr == subtract_accumulator_with_borrow_pkg::INDEX_OFS);
  wire hit_maddr = (paddr == subtract_accumulator_with_borrow_pkg::MADDR_OFS);
  wire hit_mdata = (paddr == subtract_accumulator_with_borrow_pkg::MDATA_OFS);
  wire hit_res = (paddr == subtract_accumulator_with_borrow_pkg::RESULT_OFS);
  wire mapped = hit_ctrl | hit_instr | hit_acc | hit_bank | hit_stat |
    hit_index | hit_maddr | hit_mdata | hit_res;
  // Ready only in idle and only after prdata_q was loaded in idle, so
  // read data never lags a register update made by the last phase.
  assign pready = ce & idle & valid_q;
  assign pslverr = pready & ~mapped;
  assign prdata = prdata_q;
  wire wr = psel & penable & pready & pwrite & mapped;
  wire done = psel & penable & pready;

  // Read multiplexer.
  wire [31:0] status_word = {22'h0, busy, bad_q, 3'h0, flags_q};
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0, ext_q} :
    hit_instr ? {16'h0, instr_q} :
    hit_acc ? {24'h0, w_q} :
    hit_bank ? {28'h0, bank_q} :
    hit_stat ? status_word :
    hit_index ? {20'h0, index_q} :
    hit_maddr ? {20'h0, maddr_q} :
    hit_mdata ? {24'h0, mem[maddr_q]} :
    hit_res ? {12'h0, ea_q, res_q} : 32'h0;

  // Instruction fields and datapath.
  wire [7:0] f_fld = instr_q[7:0];
  wire a_fld = instr_q[subtract_accumulator_with_borrow_pkg::A_BIT];
  wire d_fld = instr_q[subtract_accumulator_with_borrow_pkg::D_BIT];
  wire opcode_ok = (instr_q[15:10] == subtract_accumulator_with_borrow_pkg::OPCODE);
  wire borrow = ~flags_q[subtract_accumulator_with_borrow_pkg::C_BIT];
  wire [8:0] diff = sub_borrow(oper_q, w_q, borrow);
  wire [4:0] ndiff = {1'b0, oper_q[3:0]} - {1'b0, w_q[3:0]} -
    {4'h0, borrow};
  wire ovf = (oper_q[7] != w_q[7]) && (diff[7] != oper_q[7]);
  wire [4:0] new_flags = {diff[7], ovf, (diff[7:0] == 8'h00), ~ndiff[4],
    ~diff[8]};
  wire [11:0] ea_d = resolve(f_fld, a_fld, ext_q, bank_q, index_q);

  // Phase sequencer; each phase is one enabled clock.
  always_comb begin
    state_d = state_q;
    case (state_q)
      subtract_accumulator_with_borrow_pkg::ST_IDLE: begin
        if (wr && hit_instr) begin
          state_d = subtract_accumulator_with_borrow_pkg::ST_DECODE;
        end
      end
      subtract_accumulator_with_borrow_pkg::ST_DECODE: begin
        state_d = opcode_ok ? subtract_accumulator_with_borrow_pkg::ST_READ
                  : subtract_accumulator_with_borrow_pkg::ST_IDLE;
      end
      subtract_accumulator_with_borrow_pkg::ST_READ: state_d = subtract_accumulator_with_borrow_pkg::ST_PROCESS;
      subtract_accumulator_with_borrow_pkg::ST_PROCESS: state_d = subtract_accumulator_with_borrow_pkg::ST_WRITE;
      subtract_accumulator_with_borrow_pkg::ST_WRITE: state_d = subtract_accumulator_with_borrow_pkg::ST_IDLE;
      default: state_d = subtract_accumulator_with_borrow_pkg::ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= subtract_accumulator_with_borrow_pkg::ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Bus read capture; reloaded every idle cycle of a transfer.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0;
      valid_q <= 1'b0;
    end else if (ce) begin
      if (psel && idle) begin
        prdata_q <= rd_mux;
      end
      valid_q <= psel & idle & ~done;
    end
  end

  // Software configuration registers.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_q <= 1'b0;
      instr_q <= 16'h0;
      bank_q <= 4'h0;
      index_q <= 12'h0;
      maddr_q <= 12'h0;
    end else if (ce && wr) begin
      if (hit_ctrl) ext_q <= pwdata[subtract_accumulator_with_borrow_pkg::EXT_BIT];
      if (hit_instr) instr_q <= pwdata[15:0];
      if (hit_bank) bank_q <= pwdata[3:0];
      if (hit_index) index_q <= pwdata[11:0];
      if (hit_maddr) maddr_q <= pwdata[11:0];
    end
  end

  // Operand address, operand fetch and compute pipeline.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ea_q <= 12'h0;
      oper_q <= 8'h0;
      res_q <= 8'h0;
      calc_q <= subtract_accumulator_with_borrow_pkg::FLAGS_RESET;
    end else if (ce) begin
      if (state_q == subtract_accumulator_with_borrow_pkg::ST_DECODE) ea_q <= ea_d;
      if (state_q == subtract_accumulator_with_borrow_pkg::ST_READ) oper_q <= mem[ea_q];
      if (state_q == subtract_accumulator_with_borrow_pkg::ST_PROCESS) begin
        res_q <= diff[7:0];
        calc_q <= new_flags;
      end
    end
  end

  // Accumulator: written by software or by the write phase.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      w_q <= 8'h0;
    end else if (ce) begin
      if (state_q == subtract_accumulator_with_borrow_pkg::ST_WRITE && !d_fld) begin
        w_q <= res_q;
      end else if (wr && hit_acc) begin
        w_q <= pwdata[7:0];
      end
    end
  end

  // Status flags; the write phase wins over a software write, and a
  // rejected opcode sets the sticky bad bit ahead of a write-one clear.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= subtract_accumulator_with_borrow_pkg::FLAGS_RESET;
      bad_q <= 1'b0;
    end else if (ce) begin
      if (state_q == subtract_accumulator_with_borrow_pkg::ST_WRITE) begin
        flags_q <= calc_q;
      end else if (wr && hit_stat) begin
        flags_q <= pwdata[4:0];
      end
      if (state_q == subtract_accumulator_with_borrow_pkg::ST_DECODE && !opcode_ok) begin
        bad_q <= 1'b1;
      end else if (wr && hit_stat && pwdata[subtract_accumulator_with_borrow_pkg::BAD_BIT]) begin
        bad_q <= 1'b0;
      end
    end
  end

  // Data memory; no reset, since software initialises what it uses.
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (state_q == subtract_accumulator_with_borrow_pkg::ST_WRITE && d_fld) begin
        mem[ea_q] <= res_q;
      end else if (wr && hit_mdata) begin
        mem[maddr_q] <= pwdata[7:0];
      end
    end
  end

  // Checks on the execution path.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  wire in_dec = ce && (state_q == subtract_accumulator_with_borrow_pkg::ST_DECODE);
  wire in_wr = ce && (state_q == subtract_accumulator_with_borrow_pkg::ST_WRITE);

  sequence run_s;
    (in_dec && opcode_ok) ##1 (ce && state_q == subtract_accumulator_with_borrow_pkg::ST_READ)
    ##1 (ce && state_q == subtract_accumulator_with_borrow_pkg::ST_PROCESS);
  endsequence

  sequence reject_s;
    in_dec && !opcode_ok;
  endsequence

  decode_reject_a: assert property (
    reject_s |=> idle && bad_q)
    else $error("Foreign opcode was not rejected.");

  diff_value_a: assert property (
    run_s |=> res_q == 8'($past(oper_q) - $past(w_q)
      - {7'h0, ~$past(flags_q[subtract_accumulator_with_borrow_pkg::C_BIT])}))
    else $error("Difference is not operand minus accumulator minus borrow.");

  access_bank_a: assert property (
    in_dec && !a_fld && !(ext_q && f_fld <= subtract_accumulator_with_borrow_pkg::INDEX_LIMIT)
    |=> ea_q == {(f_fld < subtract_accumulator_with_borrow_pkg::ACCESS_SPLIT) ?
      subtract_accumulator_with_borrow_pkg::LOW_BANK : subtract_accumulator_with_borrow_pkg::HIGH_BANK, f_fld})
    else $error("Access bank address is wrong.");

  banked_addr_a: assert property (
    in_dec && a_fld |=> ea_q == {$past(bank_q), $past(f_fld)})
    else $error("Bank pointer was not used for the operand address.");

  indexed_addr_a: assert property (
    in_dec && !a_fld && ext_q && f_fld <= subtract_accumulator_with_borrow_pkg::INDEX_LIMIT
    |=> ea_q == 12'($past(index_q) + {4'h0, $past(f_fld)}))
    else $error("Indexed literal offset address is wrong.");

  phase_order_a: assert property (
    run_s ##1 ce |-> state_q == subtract_accumulator_with_borrow_pkg::ST_WRITE ##1 idle)
    else $error("Phases did not run decode, read, process, write.");

  zero_flag_a: assert property (
    in_wr |=> flags_q[subtract_accumulator_with_borrow_pkg::Z_BIT] == (res_q == 8'h00))
    else $error("Zero flag disagrees with the difference.");

  neg_flag_a: assert property (
    in_wr |=> flags_q[subtract_accumulator_with_borrow_pkg::N_BIT] == res_q[7])
    else $error("Negative flag disagrees with bit seven.");

  carry_flag_a: assert property (
    run_s ##1 ce |=> flags_q[subtract_accumulator_with_borrow_pkg::C_BIT] ==
      ({1'b0, $past(oper_q, 2)} >= {1'b0, $past(w_q, 2)}
        + {8'h0, ~$past(flags_q[subtract_accumulator_with_borrow_pkg::C_BIT], 2)}))
    else $error("Carry flag does not show absence of borrow.");

  acc_dest_a: assert property (
    in_wr && !d_fld |=> w_q == $past(res_q))
    else $error("Accumulator was not written with the difference.");

  // The low-nibble borrow uses the carry as it stood before the write.
  nibble_carry_a: assert property (
    in_wr |=> flags_q[subtract_accumulator_with_borrow_pkg::NIBBLE_BIT] ==
      ({1'b0, $past(oper_q[3:0])} >= {1'b0, $past(w_q[3:0])}
        + {4'h0, ~$past(flags_q[subtract_accumulator_with_borrow_pkg::C_BIT])}))
    else $error("Nibble carry flag does not show absence of borrow.");

  signed_wrap_a: assert property (
    in_wr |=> flags_q[subtract_accumulator_with_borrow_pkg::WRAP_BIT] ==
      ($past(oper_q[7]) != $past(w_q[7]) &&
        res_q[7] != $past(oper_q[7])))
    else $error("Signed wrap flag disagrees with the operand signs.");

  instr_start_a: assert property (
    ce && wr && hit_instr |=> state_q == subtract_accumulator_with_borrow_pkg::ST_DECODE)
    else $error("An instruction write did not start the decode phase.");

  freeze_state_a: assert property (
    !ce |=> $stable(state_q) && $stable(flags_q))
    else $error("State moved while the clock enable was low.");

endmodule : subtract_with_borrow_exec

// *** subtract_with_borrow_exec_test.sv ***
// Purpose: Self-checking bench for the subtract-with-borrow execution block.
// Assumes: APB master here; reads are checked against a queue of notes.
// Notes: Operands come from a few fixed cases plus seeded random trials.
`timescale 1ns/1ns
module subtract_with_borrow_exec_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [32:0] exp_q[$];
  int fail_count = 0;
  int n_tests = 0;
  int seed = 32'h3039;

  // Free-running clock at 10 MHz.
  always #50 mclk = ~mclk;

  subtract_with_borrow_exec dut (.mclk(mclk), .arst_n(arst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_rd(input logic [32:0] exp, input logic [32:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL read %h expected %h seen %h", paddr, exp, got);
    end
  endtask : check_rd

  // Each completed read takes the oldest note; pre-edge values are sampled.
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check_rd(exp_q.pop_front(), {pslverr, prdata});
    end
  end

  // Request held until the rising edge at which pready is seen high; the
  // release is made at that same edge, so the bus rests one cycle between.
  task automatic xfer(input logic wr, input logic [11:0] ad,
                      input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 300);
    if (k >= 300) begin
      fail_count++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [32:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, ad, 32'h0);
  endtask : rd

  // Expected {N, wrap, Z, nibble carry, C, difference}, worked out apart.
  function automatic logic [12:0] model(input logic [7:0] f,
                                        input logic [7:0] w, input logic c);
    logic [8:0] full;
    logic [4:0] lo;
    logic [7:0] r;
    full = {1'b0, f} - {1'b0, w} - {8'h00, ~c};
    lo = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, ~c};
    r = full[7:0];
    return {r[7], (f[7] != w[7]) && (r[7] != f[7]), r == 8'h00, ~lo[4],
            ~full[8], r};
  endfunction : model

  task automatic trial(input logic [7:0] fv, input logic [7:0] w,
    input logic c, input logic a, input logic d, input logic ext,
    input logic [3:0] bank, input logic [11:0] idx, input logic [7:0] fa);
    logic [11:0] oa;
    logic [12:0] m;
    if (a) oa = {bank, fa};
    else if (ext && fa <= 8'h5f) oa = idx + {4'h0, fa};
    else oa = (fa < 8'h60) ? {4'h0, fa} : {4'hf, fa};
    m = model(fv, w, c);
    wr(subtract_accumulator_with_borrow_pkg::CTRL_OFS, {31'h0, ext});
    wr(subtract_accumulator_with_borrow_pkg::BANK_OFS, {28'h0, bank});
    wr(subtract_accumulator_with_borrow_pkg::INDEX_OFS, {20'h0, idx});
    wr(subtract_accumulator_with_borrow_pkg::ACC_OFS, {24'h0, w});
    wr(subtract_accumulator_with_borrow_pkg::STATUS_OFS, {31'h0, c});
    wr(subtract_accumulator_with_borrow_pkg::MADDR_OFS, {20'h0, oa});
    wr(subtract_accumulator_with_borrow_pkg::MDATA_OFS, {24'h0, fv});
    wr(subtract_accumulator_with_borrow_pkg::INSTR_OFS, {16'h0, subtract_accumulator_with_borrow_pkg::OPCODE, d, a, fa});
    rd(subtract_accumulator_with_borrow_pkg::RESULT_OFS, {13'h0, oa, m[7:0]});
    rd(subtract_accumulator_with_borrow_pkg::STATUS_OFS, {28'h0, m[12:8]});
    rd(subtract_accumulator_with_borrow_pkg::ACC_OFS, {25'h0, d ? w : m[7:0]});
    rd(subtract_accumulator_with_borrow_pkg::MDATA_OFS, {25'h0, d ? m[7:0] : fv});
  endtask : trial

  // Watchdog sized well above the expected run length.
  initial begin
    #(100 * 80000);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    rd(subtract_accumulator_with_borrow_pkg::STATUS_OFS, 33'h0);
    rd(subtract_accumulator_with_borrow_pkg::ACC_OFS, 33'h0);
    $display("test reset done");
    trial(8'h19, 8'h0d, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 12'h0, 8'h20);
    trial(8'h1b, 8'h1a, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 12'h0, 8'h80);
    trial(8'h03, 8'h0e, 1'b1, 1'b1, 1'b1, 1'b0, 4'h3, 12'h0, 8'h44);
    trial(8'h80, 8'h01, 1'b1, 1'b0, 1'b1, 1'b1, 4'h2, 12'h7f0, 8'h5f);
    trial(8'h7f, 8'hff, 1'b0, 1'b0, 1'b0, 1'b1, 4'h2, 12'h300, 8'h60);
    $display("test fixed cases done");
    repeat (30) begin
      trial(8'($random(seed)), 8'($random(seed)), 1'($random(seed)),
            1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
            4'($random(seed)), 12'($random(seed)), 8'($random(seed)));
    end
    $display("test random cases done");
    // A foreign opcode marks the sticky error bit; flags and accumulator keep their values.
    wr(subtract_accumulator_with_borrow_pkg::ACC_OFS, 32'h55);
    wr(subtract_accumulator_with_borrow_pkg::STATUS_OFS, 32'h1f);
    wr(subtract_accumulator_with_borrow_pkg::INSTR_OFS, {16'h0, 6'h17, 10'h3ff});
    rd(subtract_accumulator_with_borrow_pkg::STATUS_OFS, 33'h11f);
    rd(subtract_accumulator_with_borrow_pkg::ACC_OFS, 33'h55);
    wr(subtract_accumulator_with_borrow_pkg::STATUS_OFS, 32'h100);
    rd(subtract_accumulator_with_borrow_pkg::STATUS_OFS, 33'h0);
    rd(12'h024, {1'b1, 32'h0});
    $display("test refusals done");
    // A read held while the clock enable is low must still finish.
    ce <= 1'b0;
    fork
      rd(subtract_accumulator_with_borrow_pkg::ACC_OFS, 33'h55);
      begin
        repeat (6) @(posedge mclk);
        ce <= 1'b1;
      end
    join
    // Reset in mid-run clears the registers again.
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    rd(subtract_accumulator_with_borrow_pkg::ACC_OFS, 33'h0);
    rd(subtract_accumulator_with_borrow_pkg::CTRL_OFS, 33'h0);
    $display("test stall and reset done");
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule : subtract_with_borrow_exec_test
